// ==== usp_defs.svh ====
// offsets, field positions, reset values and timing counts of the usb status and pin block
//
// Summary of operation
// - status output A asserts during host bus reset when that condition is chosen
// - status output A asserts while suspended when that condition is chosen
// - max power at most one unit load: current condition means suspended only
// - max power above one unit load: current condition means suspended or unconfigured
// - software picks polarity and conditions; output deasserts when none holds
// - after reset output A is active high and asserts only while suspended
// - output B offers same choices, defaults active low, asserts during suspend
// - terminal-ready shared pin leaves reset as push-pull general-purpose output
// - ring/wake and carrier pins leave reset as inputs with pull-up
// - ring indicate and remote wake inputs are active low when assigned
// - clear-to-send pin leaves reset as modem input with pull-up
// - request-to-send pin: gpio, active-low output or rs485 enable; default open drain
// - rx activity pin defaults to indicator, toggles about ten hertz while receiving
// - tx activity pin defaults to indicator, toggles about ten hertz while transmitting
`ifndef USP_DEFS_SVH
`define USP_DEFS_SVH

`define USP_ADDR_CFG_A 8'h00
`define USP_ADDR_CFG_B 8'h04
`define USP_ADDR_POWER 8'h08
`define USP_ADDR_PIN_MODE 8'h0c
`define USP_ADDR_GPIO 8'h10
`define USP_ADDR_STATUS 8'h14

// status config: bit0 polarity (1 = active low), bit1 reset, bit2 suspend, bit3 current
`define USP_CFG_POL 0
`define USP_CFG_SEL_LO 1
`define USP_CFG_A_RST 4'h4
`define USP_CFG_B_RST 4'h5

`define USP_ONE_UNIT_LOAD 8'h32
`define USP_POWER_RST 8'h32

// pin mode fields
`define USP_PM_DTR 0
`define USP_PM_RW_LO 1
`define USP_PM_CD 3
`define USP_PM_CTS 4
`define USP_PM_RTS_LO 5
`define USP_PM_RTS_OD 7
`define USP_PM_RXA 8
`define USP_PM_TXA 9
`define USP_PIN_MODE_RST 10'h3b0

// pin indices
`define USP_NPINS 7
`define USP_PIN_RTS 0
`define USP_PIN_CTS 1
`define USP_PIN_RXA 2
`define USP_PIN_TXA 3
`define USP_PIN_CD 4
`define USP_PIN_RW 5
`define USP_PIN_DTR 6

// gpio register: out [6:0], dir [14:8], pull-up [22:16]
`define USP_GPIO_DIR_LO 8
`define USP_GPIO_PU_LO 16
`define USP_GPIO_OUT_RST 7'h00
`define USP_GPIO_DIR_RST 7'h40
`define USP_GPIO_PU_RST 7'h32

`define USP_CLK_HZ 10000000
`define USP_ACT_INTERVAL_MS 100
`define USP_ACT_CYCLES ((`USP_CLK_HZ / 1000) * `USP_ACT_INTERVAL_MS)

`endif

// ==== usp_pkg.sv ====
// types shared by the usb status and pin block
package usp_pkg;

    typedef enum logic [1:0] {
        USP_RW_GPIO = 2'h0,
        USP_RW_RING = 2'h1,
        USP_RW_WAKE = 2'h2
    } usp_rw_fn_e;

    typedef enum logic [1:0] {
        USP_RTS_GPIO = 2'h0,
        USP_RTS_MODEM = 2'h1,
        USP_RTS_RS485 = 2'h2
    } usp_rts_fn_e;

endpackage

// ==== usp_act_if.sv ====
// carrier between the pin block and its activity indicator engine
`timescale 1ns/10ps
interface usp_act_if;
    logic [1:0] busy;
    logic [1:0] ind;
    modport ctl (output busy, input ind);
    modport act (input busy, output ind);
endinterface

// ==== usp_activity.sv ====
// activity indicator engine: shared interval divider, one toggle per channel
`timescale 1ns/10ps
`include "usp_defs.svh"
module usp_activity #(
    parameter int unsigned TOGGLE_CYCLES = `USP_ACT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    usp_act_if.act act
);
    import usp_pkg::*;

    localparam int CW = $clog2(TOGGLE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TOGGLE_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [1:0] ind;
    } usp_act_s;

    usp_act_s r;
    usp_act_s next_r;
    logic tick;

    assign tick = (r.cnt == LAST);

    always_comb
    begin
        next_r = r;
        next_r.cnt = tick ? '0 : r.cnt + 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            if (tick && act.busy[i])
                next_r.ind[i] = ~r.ind[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign act.ind = r.ind;
endmodule

// ==== usp_top.sv ====
// usb status outputs, shared modem/gpio pin muxing and activity indicators behind apb
`timescale 1ns/10ps
`include "usp_defs.svh"
module usp_top #(
    parameter int unsigned ACT_TOGGLE_CYCLES = `USP_ACT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic usb_bus_reset,
    input wire logic usb_suspended,
    input wire logic usb_configured,
    input wire logic uart_rx_busy,
    input wire logic uart_tx_busy,
    input wire logic terminal_ready,
    input wire logic request_to_send,
    input wire logic rs485_tx_enable,
    output logic usb_state_out_a,
    output logic usb_state_out_b,
    input wire logic [`USP_NPINS-1:0] pin_in,
    output logic [`USP_NPINS-1:0] pin_out,
    output logic [`USP_NPINS-1:0] pin_oe,
    output logic [`USP_NPINS-1:0] pin_pullup,
    output logic ring_indicate,
    output logic remote_wake_in,
    output logic carrier_detect,
    output logic clear_to_send,
    output usp_pkg::usp_rw_fn_e ring_wake_mode
);
    import usp_pkg::*;

    localparam int NP = `USP_NPINS;

    typedef struct packed {
        logic [3:0] cfg_a;
        logic [3:0] cfg_b;
        logic [7:0] max_power;
        logic [9:0] pin_mode;
        logic [NP-1:0] gpio_out;
        logic [NP-1:0] gpio_dir;
        logic [NP-1:0] gpio_pu;
        logic [NP-1:0] sync1;
        logic [NP-1:0] sync2;
        logic stat_a;
        logic stat_b;
        logic [NP-1:0] pout;
        logic [NP-1:0] poe;
        logic [NP-1:0] ppu;
        logic ring;
        logic wake;
        logic cd;
        logic cts;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } usp_state_s;

    usp_state_s r;
    usp_state_s next_r;

    usp_act_if act_bus ();

    usp_activity #(
        .TOGGLE_CYCLES(ACT_TOGGLE_CYCLES)
    ) u_activity (
        .pclk(pclk),
        .presetn(presetn),
        .act(act_bus)
    );

    // indicators run only while the uart is busy
    assign act_bus.busy = {uart_tx_busy, uart_rx_busy};

    // current-safety condition depends on configured budget
    logic power_unsafe;
    assign power_unsafe = (r.max_power > `USP_ONE_UNIT_LOAD) ? (usb_suspended || !usb_configured)
                                                             : usb_suspended;

    // chosen conditions, then polarity; nothing chosen gives deasserted
    function automatic logic stat_eval(input logic [3:0] cfg, input logic rst_c, input logic sus_c,
                                       input logic pwr_c);
        logic [2:0] sel;
        logic cond;
        sel = cfg[`USP_CFG_SEL_LO +: 3];
        cond = (sel[0] && rst_c) || (sel[1] && sus_c) || (sel[2] && pwr_c);
        return cond ^ cfg[`USP_CFG_POL];
    endfunction

    logic apb_setup;
    logic apb_done;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [31:0] gpio_word;

    assign apb_setup = psel && penable && !r.ready;
    assign apb_done = psel && penable && r.ready;
    // register slot is a word; low two address bits must be zero
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `USP_ADDR_STATUS);

    always_comb
    begin
        gpio_word = '0;
        gpio_word[NP-1:0] = r.gpio_out;
        gpio_word[`USP_GPIO_DIR_LO +: NP] = r.gpio_dir;
        gpio_word[`USP_GPIO_PU_LO +: NP] = r.gpio_pu;
    end

    assign status_word = {18'h0, usb_configured, power_unsafe, usb_suspended, usb_bus_reset,
                          r.stat_b, r.stat_a, 1'b0, r.sync2};

    always_comb
    begin
        case (paddr)
            `USP_ADDR_CFG_A: rd_mux = {28'h0, r.cfg_a};
            `USP_ADDR_CFG_B: rd_mux = {28'h0, r.cfg_b};
            `USP_ADDR_POWER: rd_mux = {24'h0, r.max_power};
            `USP_ADDR_PIN_MODE: rd_mux = {22'h0, r.pin_mode};
            `USP_ADDR_GPIO: rd_mux = gpio_word;
            `USP_ADDR_STATUS: rd_mux = status_word;
            default: rd_mux = 32'h0;
        endcase
    end

    // per-pin function value, whether that function drives, and whether function is selected
    logic [NP-1:0] fn_sel;
    logic [NP-1:0] fn_val;
    logic [NP-1:0] fn_oe;
    usp_rw_fn_e rw_fn;
    usp_rts_fn_e rts_fn;
    logic rts_val;

    assign rw_fn = usp_rw_fn_e'(r.pin_mode[`USP_PM_RW_LO +: 2]);
    assign rts_fn = usp_rts_fn_e'(r.pin_mode[`USP_PM_RTS_LO +: 2]);

    always_comb
    begin
        fn_sel = '0;
        fn_val = '0;
        fn_oe = '0;
        rts_val = 1'b1;
        // rts pin: active-low modem output or rs485 direction enable
        case (rts_fn)
            USP_RTS_MODEM: rts_val = ~request_to_send;
            USP_RTS_RS485: rts_val = rs485_tx_enable;
            default: rts_val = 1'b1;
        endcase
        fn_sel[`USP_PIN_RTS] = (rts_fn != USP_RTS_GPIO);
        if (r.pin_mode[`USP_PM_RTS_OD])
        begin
            // open drain: only ever pull low
            fn_val[`USP_PIN_RTS] = 1'b0;
            fn_oe[`USP_PIN_RTS] = ~rts_val;
        end
        else
        begin
            fn_val[`USP_PIN_RTS] = rts_val;
            fn_oe[`USP_PIN_RTS] = 1'b1;
        end
        fn_sel[`USP_PIN_CTS] = r.pin_mode[`USP_PM_CTS];
        fn_sel[`USP_PIN_RXA] = r.pin_mode[`USP_PM_RXA];
        fn_val[`USP_PIN_RXA] = act_bus.ind[0];
        fn_oe[`USP_PIN_RXA] = 1'b1;
        fn_sel[`USP_PIN_TXA] = r.pin_mode[`USP_PM_TXA];
        fn_val[`USP_PIN_TXA] = act_bus.ind[1];
        fn_oe[`USP_PIN_TXA] = 1'b1;
        // carrier and ring/wake pins are inputs in their modem role
        fn_sel[`USP_PIN_CD] = r.pin_mode[`USP_PM_CD];
        fn_sel[`USP_PIN_RW] = (rw_fn != USP_RW_GPIO);
        fn_sel[`USP_PIN_DTR] = r.pin_mode[`USP_PM_DTR];
        fn_val[`USP_PIN_DTR] = ~terminal_ready;
        fn_oe[`USP_PIN_DTR] = 1'b1;
    end

    logic [NP-1:0] mux_out;
    logic [NP-1:0] mux_oe;

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_pin
            assign mux_out[gi] = fn_sel[gi] ? fn_val[gi] : r.gpio_out[gi];
            assign mux_oe[gi] = fn_sel[gi] ? fn_oe[gi] : r.gpio_dir[gi];
        end
    endgenerate

    always_comb
    begin
        next_r = r;
        // pins come from another domain: two flops before use
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;

        next_r.stat_a = stat_eval(r.cfg_a, usb_bus_reset, usb_suspended, power_unsafe);
        next_r.stat_b = stat_eval(r.cfg_b, usb_bus_reset, usb_suspended, power_unsafe);

        next_r.pout = mux_out;
        next_r.poe = mux_oe;
        next_r.ppu = r.gpio_pu;

        // active-low modem inputs, reported high when asserted
        next_r.ring = (rw_fn == USP_RW_RING) && !r.sync2[`USP_PIN_RW];
        next_r.wake = (rw_fn == USP_RW_WAKE) && !r.sync2[`USP_PIN_RW];
        next_r.cd = r.pin_mode[`USP_PM_CD] && !r.sync2[`USP_PIN_CD];
        next_r.cts = r.pin_mode[`USP_PM_CTS] && !r.sync2[`USP_PIN_CTS];

        // one wait state: answer registered, so every bus output is a flop
        next_r.ready = apb_setup;
        if (apb_setup)
        begin
            next_r.slverr = !addr_ok;
            next_r.rdata = (pwrite || !addr_ok) ? 32'h0 : rd_mux;
        end
        else if (apb_done)
        begin
            next_r.slverr = 1'b0;
            next_r.rdata = 32'h0;
        end

        // writes take effect only at the completing edge
        if (apb_done && pwrite && addr_ok)
        begin
            case (paddr)
                `USP_ADDR_CFG_A: next_r.cfg_a = pwdata[3:0];
                `USP_ADDR_CFG_B: next_r.cfg_b = pwdata[3:0];
                `USP_ADDR_POWER: next_r.max_power = pwdata[7:0];
                `USP_ADDR_PIN_MODE: next_r.pin_mode = pwdata[9:0];
                `USP_ADDR_GPIO:
                begin
                    next_r.gpio_out = pwdata[NP-1:0];
                    next_r.gpio_dir = pwdata[`USP_GPIO_DIR_LO +: NP];
                    next_r.gpio_pu = pwdata[`USP_GPIO_PU_LO +: NP];
                end
                default: next_r.cfg_a = r.cfg_a;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.cfg_a <= `USP_CFG_A_RST;
            r.cfg_b <= `USP_CFG_B_RST;
            r.stat_b <= 1'b1;
            r.max_power <= `USP_POWER_RST;
            r.pin_mode <= `USP_PIN_MODE_RST;
            r.gpio_out <= `USP_GPIO_OUT_RST;
            r.gpio_dir <= `USP_GPIO_DIR_RST;
            r.gpio_pu <= `USP_GPIO_PU_RST;
            r.ppu <= `USP_GPIO_PU_RST;
            r.poe <= `USP_GPIO_DIR_RST;
            r.sync1 <= '1;
            r.sync2 <= '1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata = r.rdata;
    assign pready = r.ready;
    assign pslverr = r.slverr;
    assign usb_state_out_a = r.stat_a;
    assign usb_state_out_b = r.stat_b;
    assign pin_out = r.pout;
    assign pin_oe = r.poe;
    assign pin_pullup = r.ppu;
    assign ring_indicate = r.ring;
    assign remote_wake_in = r.wake;
    assign carrier_detect = r.cd;
    assign clear_to_send = r.cts;
    assign ring_wake_mode = usp_rw_fn_e'(r.pin_mode[`USP_PM_RW_LO +: 2]);
endmodule

// ==== usp_board.sv ====
// board model: pull-ups, external drivers and floating lines on the shared pins
`timescale 1ns/10ps
module usp_board (
    input wire logic pclk,
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] pin_pullup,
    input wire logic [6:0] ext_drv,
    input wire logic [6:0] ext_val,
    output logic [6:0] pin_in
);
    logic flt = 1'b0;
    // a line nobody holds wanders, so it never passes for a clean level
    always @(posedge pclk)
        flt <= ~flt;
    always_comb
        for (int i = 0; i < 7; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pin_pullup[i] ? 1'b1 : flt;
endmodule

// ==== usp_top_props.sv ====
// port checker of the usb status and pin block
`timescale 1ns/10ps
module usp_top_props #(
    parameter int unsigned ACT_TOGGLE_CYCLES = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic usb_suspended,
    input wire logic uart_rx_busy,
    input wire logic uart_tx_busy,
    input wire logic request_to_send,
    input wire logic usb_state_out_a,
    input wire logic usb_state_out_b,
    input wire logic [6:0] pin_in,
    input wire logic [6:0] pin_out,
    input wire logic [6:0] pin_oe,
    input wire logic [6:0] pin_pullup,
    input wire logic ring_indicate,
    input wire logic remote_wake_in,
    input wire usp_pkg::usp_rw_fn_e ring_wake_mode
);
    import usp_pkg::*;

    logic dflt;
    logic [1:0] age;
    logic [7:0] rxq;
    logic [7:0] txq;
    logic rxp;
    logic txp;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // any completed write may leave the defaults, so those checks stop there
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dflt <= 1'b1;
            age <= 2'h0;
            rxq <= 8'h00;
            txq <= 8'h00;
            rxp <= 1'b0;
            txp <= 1'b0;
        end
        else
        begin
            dflt <= dflt && !(psel && penable && pready && pwrite);
            age <= (age == 2'h3) ? age : age + 2'h1;
            rxq <= (!uart_rx_busy || pin_out[2] != rxp) ? 8'h00 : rxq + 8'h01;
            txq <= (!uart_tx_busy || pin_out[3] != txp) ? 8'h00 : txq + 8'h01;
            rxp <= pin_out[2];
            txp <= pin_out[3];
        end
    end
    AST_APB_WAIT: assert property (age != 2'h0 && psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without error");
    AST_STAT_A_DFLT: assert property (dflt && age == 2'h3 |-> usb_state_out_a == $past(usb_suspended))
        else $error("status a default wrong");
    AST_STAT_B_DFLT: assert property (dflt && age == 2'h3 |-> usb_state_out_b == !$past(usb_suspended))
        else $error("status b default wrong");
    AST_PIN_DFLT: assert property (dflt && age == 2'h3 |-> pin_pullup == 7'h32 && pin_oe[6:1] == 6'h26)
        else $error("pin defaults wrong");
    AST_RTS_OD: assert property (dflt && age == 2'h3 |-> !pin_out[0] && pin_oe[0] == $past(request_to_send))
        else $error("rts open drain wrong");
    AST_RING: assert property ((ring_wake_mode == USP_RW_RING && !pin_in[5])[*5] |-> ring_indicate)
        else $error("ring indicate missing");
    AST_WAKE: assert property ((ring_wake_mode == USP_RW_WAKE && !pin_in[5])[*5] |-> remote_wake_in)
        else $error("remote wake missing");
    AST_RX_TOGGLE: assert property (dflt |-> rxq <= ACT_TOGGLE_CYCLES + 1)
        else $error("rx indicator not toggling");
    AST_TX_TOGGLE: assert property (dflt |-> txq <= ACT_TOGGLE_CYCLES + 1)
        else $error("tx indicator not toggling");
    AST_RX_HOLD: assert property ((dflt && !uart_rx_busy)[*3] |=> $stable(pin_out[2]))
        else $error("rx indicator moved while idle");
    cover property (pready && pslverr);
    cover property (ring_indicate);
    cover property (dflt && uart_rx_busy && $changed(pin_out[2]));
endmodule

// ==== testbench.sv ====
// self-checking bench of the usb status and pin block
`timescale 1ns/10ps
`include "usp_defs.svh"
bind usp_top usp_top_props #(.ACT_TOGGLE_CYCLES(ACT_TOGGLE_CYCLES)) usp_top_props_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .usb_suspended, .uart_rx_busy, .uart_tx_busy, .request_to_send,
    .usb_state_out_a, .usb_state_out_b, .pin_in, .pin_out, .pin_oe, .pin_pullup, .ring_indicate, .remote_wake_in,
    .ring_wake_mode);
module testbench;
    import usp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    // bus reset, suspended, configured, rx, tx, terminal ready, rts, rs485
    logic [7:0] ctl = 8'h00;
    logic [6:0] ext_drv = 7'h00;
    logic [6:0] ext_val = 7'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sa;
    logic sb;
    logic [6:0] pin_in;
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
    logic [6:0] pin_pullup;
    logic ring;
    logic wake;
    logic cd;
    logic cts;
    usp_rw_fn_e rw_mode;
    logic [31:0] rd;
    logic er;
    logic last;
    int cnt;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rv [5] = '{32'h4, 32'h5, 32'h32, 32'h3b0, 32'h00324000};
    usp_top #(.ACT_TOGGLE_CYCLES(8)) usp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .usb_bus_reset(ctl[0]), .usb_suspended(ctl[1]), .usb_configured(ctl[2]), .uart_rx_busy(ctl[3]),
        .uart_tx_busy(ctl[4]), .terminal_ready(ctl[5]), .request_to_send(ctl[6]), .rs485_tx_enable(ctl[7]),
        .usb_state_out_a(sa), .usb_state_out_b(sb), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ring_indicate(ring), .remote_wake_in(wake), .carrier_detect(cd),
        .clear_to_send(cts), .ring_wake_mode(rw_mode));
    usp_board usp_board_i (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
    always #50 pclk = ~pclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    // no cycle limit here: only the watchdog ends a wait for the answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // drive the usb state inputs, then look at status output a
    task automatic sa_is(input logic [2:0] c, input logic e);
        ctl[2:0] <= c;
        cyc(3);
        chk("out_a", 32'(e), 32'(sa));
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cyc(3);
        chk("pin_oe", 32'h4c, 32'(pin_oe));
        chk("pullup", 32'h32, 32'(pin_pullup));
        // carrier and clear-to-send lines pulled low from outside
        ext_drv <= 7'h12;
        cyc(6);
        chk("modem in", 32'h1, 32'({cd, cts}));
        ctl[6] <= 1'b1;
        cyc(3);
        chk("rts od", 32'h1, 32'({pin_out[0], pin_oe[0]}));
        sa_is(3'h2, 1'b1);
        chk("out_b", 32'h0, 32'(sb));
        sa_is(3'h1, 1'b0);
        chk("out_b", 32'h1, 32'(sb));
        ctl[0] <= 1'b0;
        for (int i = 3; i < 5; i++)
        begin
            ctl[i] <= 1'b1;
            cnt = 0;
            last = pin_out[i - 1];
            repeat (40)
            begin
                @(posedge pclk);
                cnt += int'(pin_out[i - 1] !== last);
                last = pin_out[i - 1];
            end
            chk("toggles", 32'h1, 32'(cnt >= 4 && cnt <= 5));
            ctl[i] <= 1'b0;
            cyc(3);
            last = pin_out[i - 1];
            cyc(20);
            chk("hold", 32'(last), 32'(pin_out[i - 1]));
        end
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rv[i], rd);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h2, 32'({er, rd !== 32'h0}));
        apb(1'b1, `USP_ADDR_CFG_A, 32'h2);
        sa_is(3'h1, 1'b1);
        apb(1'b1, `USP_ADDR_CFG_A, 32'h3);
        cyc(3);
        chk("out_a", 32'h0, 32'(sa));
        sa_is(3'h0, 1'b1);
        apb(1'b1, `USP_ADDR_CFG_B, 32'h2);
        sa_is(3'h1, 1'b0);
        chk("out_b", 32'h1, 32'(sb));
        apb(1'b1, `USP_ADDR_CFG_A, 32'h8);
        sa_is(3'h0, 1'b0);
        sa_is(3'h2, 1'b1);
        apb(1'b1, `USP_ADDR_POWER, 32'h33);
        sa_is(3'h0, 1'b1);
        sa_is(3'h4, 1'b0);
        sa_is(3'h6, 1'b1);
        apb(1'b1, `USP_ADDR_PIN_MODE, 32'h3b2);
        ext_drv[5] <= 1'b1;
        cyc(6);
        chk("ring", 32'h2, 32'({ring, wake}));
        apb(1'b1, `USP_ADDR_PIN_MODE, 32'h35c);
        ctl[7] <= 1'b1;
        cyc(6);
        chk("wake", 32'h1, 32'({ring, wake}));
        chk("rw mode", 32'h2, 32'(rw_mode));
        chk("carrier", 32'h1, 32'(cd));
        chk("rs485", 32'h3, 32'({pin_out[0], pin_oe[0]}));
        apb(1'b1, `USP_ADDR_GPIO, 32'h00324040);
        cyc(3);
        chk("dtr gpio", 32'h1, 32'(pin_out[6]));
        results;
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        results;
    end
endmodule
